// ### core/dacdec_core.sv
/*
 Register decoder of a dual voltage-output DAC: decodes serial frames,
 holds channel codes, ranges, configuration and power status.
 Assumes analog detectors drive level inputs asynchronous to clk and
 that the link clock idles while sys_rst is applied.
*/
`default_nettype none

module dacdec_core #(
   parameter int RES_BITS = 16
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        sclk,
   input  wire logic        sync_n,
   input  wire logic        serial_data_in_pin,
   output logic             serial_data_out_pin,
   output logic             serial_data_out_oe,
   input  wire logic        chan_a_oc_detect,
   input  wire logic        chan_b_oc_detect,
   input  wire logic        overtemp_detect,
   output logic [15:0]      chan_a_code,
   output logic [15:0]      chan_b_code,
   output logic [2:0]       chan_a_range,
   output logic [2:0]       chan_b_range,
   output logic             chan_a_power_on,
   output logic             chan_b_power_on,
   output logic             clamp_enable,
   output logic             thermal_shutdown_enable,
   output logic             outputs_updated
);
   // =====
   // parameter check
   if (RES_BITS != 16 && RES_BITS != 14 && RES_BITS != 12) begin : g_res_chk
      $error("RES_BITS must be 12, 14 or 16");
   end

   localparam logic [15:0] RES_MASK = 16'hffff << (16 - RES_BITS);

   // =====
   // helpers
   function automatic logic [1:0] chan_hit(input logic [2:0] addr);
      unique case (addr)
         dacdec_pkg::ADDR_A:    chan_hit = 2'h1;
         dacdec_pkg::ADDR_B:    chan_hit = 2'h2;
         dacdec_pkg::ADDR_BOTH: chan_hit = 2'h3;
         default:               chan_hit = 2'h0;
      endcase
   endfunction : chan_hit

   // offset binary coding assumed for bipolar ranges
   function automatic logic [15:0] clear_code(input logic       lvl,
                                              input logic [2:0] rng);
      logic bip;
      bip = (rng >= dacdec_pkg::RANGE_BIPOLAR);
      if (!lvl) begin
         clear_code = bip ? dacdec_pkg::CODE_MID : dacdec_pkg::CODE_LOW;
      end else begin
         clear_code = bip ? dacdec_pkg::CODE_LOW : dacdec_pkg::CODE_MID;
      end
   endfunction : clear_code

   // =====
   // link and crossings
   dacdec_link_if lnk ();

   logic        link_rst_q;
   logic [23:0] readback_q;
   logic        tog_s;
   logic        tog_last_q;
   logic [2:0]  det_s;

   assign lnk.link_rst      = link_rst_q;
   assign lnk.readback_word = readback_q;

   dacdec_link u_link (
      .sclk                (sclk),
      .sync_n              (sync_n),
      .serial_data_in_pin  (serial_data_in_pin),
      .serial_data_out_pin (serial_data_out_pin),
      .lnk                 (lnk)
   );

   dacdec_sync #(.WIDTH(1)) u_tog_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (lnk.frame_toggle),
      .sync_out (tog_s)
   );

   dacdec_sync #(.WIDTH(3)) u_det_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({overtemp_detect, chan_b_oc_detect, chan_a_oc_detect}),
      .sync_out (det_s)
   );

   // link end is held cleared while the core is in reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_rst_q <= 1'b1;
         tog_last_q <= 1'b0;
      end else begin
         link_rst_q <= 1'b0;
         tog_last_q <= tog_s;
      end
   end

   // =====
   // frame decode
   logic        frame_new;
   logic        frame_ok;
   logic        wr_ok;
   logic        rd_ok;
   logic [2:0]  sel;
   logic [2:0]  addr;
   logic [15:0] data;
   logic [1:0]  hit;
   logic        wr_code;
   logic        wr_range;
   logic        wr_power;
   logic        wr_config;
   logic        do_clear;
   logic        do_load;

   // frame word needs no synchroniser: it stands still long after the toggle
   assign frame_new = tog_s ^ tog_last_q;
   assign sel       = lnk.frame_word[dacdec_pkg::SEL_LSB +: 3];
   assign addr      = lnk.frame_word[dacdec_pkg::ADDR_LSB +: 3];
   assign data      = lnk.frame_word[15:0];
   assign hit       = chan_hit(addr);
   // the zero bit must be clear for a frame to act
   assign frame_ok  = frame_new & ~lnk.frame_word[dacdec_pkg::ZERO_BIT];
   assign wr_ok     = frame_ok & ~lnk.frame_word[dacdec_pkg::RW_BIT];
   assign rd_ok     = frame_ok & lnk.frame_word[dacdec_pkg::RW_BIT];

   assign wr_code   = wr_ok && sel == dacdec_pkg::SEL_DAC;
   assign wr_range  = wr_ok && sel == dacdec_pkg::SEL_RANGE
                      && data[2:0] <= dacdec_pkg::RANGE_LAST;
   assign wr_power  = wr_ok && sel == dacdec_pkg::SEL_POWER
                      && addr == dacdec_pkg::ADDR_A;
   // control selects a function by address, not a channel
   assign wr_config = wr_ok && sel == dacdec_pkg::SEL_CTRL
                      && addr == dacdec_pkg::FN_CONFIG;
   assign do_clear  = wr_ok && sel == dacdec_pkg::SEL_CTRL
                      && addr == dacdec_pkg::FN_CLEAR;
   assign do_load   = wr_ok && sel == dacdec_pkg::SEL_CTRL
                      && addr == dacdec_pkg::FN_LOAD;
   // FN_NOP and other function codes fall through with no effect

   // =====
   // configuration
   logic [3:0] cfg_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q <= dacdec_pkg::CFG_RESET;
      end else if (wr_config) begin
         cfg_q <= data[3:0];
      end
   end

   // =====
   // ranges and channel codes
   logic [2:0]  range_q [2];
   logic [15:0] pend_q  [2];
   logic [15:0] out_q   [2];
   logic        upd_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         range_q[0] <= dacdec_pkg::RANGE_RESET;
         range_q[1] <= dacdec_pkg::RANGE_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_range && hit[i]) begin
               range_q[i] <= data[2:0];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 2; i++) begin
            pend_q[i] <= dacdec_pkg::CODE_RESET;
            out_q[i]  <= dacdec_pkg::CODE_RESET;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (do_clear) begin
               pend_q[i] <= clear_code(cfg_q[dacdec_pkg::CFG_CLR_SEL],
                                       range_q[i]);
               out_q[i]  <= clear_code(cfg_q[dacdec_pkg::CFG_CLR_SEL],
                                       range_q[i]);
            end else begin
               if (wr_code && hit[i]) begin
                  pend_q[i] <= data & RES_MASK;
               end
               if (do_load) begin
                  out_q[i] <= pend_q[i];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upd_q <= 1'b0;
      end else begin
         upd_q <= do_clear | do_load;
      end
   end

   // =====
   // power and alerts; hardware events win over a host write
   logic [1:0] pu_q;
   logic [1:0] oc_q;
   logic       therm_q;
   logic [1:0] pu_wr;
   logic       clamp;
   logic       hot;

   assign pu_wr = {data[dacdec_pkg::PWR_PU_B], data[dacdec_pkg::PWR_PU_A]};
   assign clamp = cfg_q[dacdec_pkg::CFG_CLAMP];
   // a detector pulse shorter than one clk period can be missed
   assign hot   = det_s[2] & cfg_q[dacdec_pkg::CFG_THERM_EN];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pu_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (hot || (det_s[i] && !clamp)) begin
               pu_q[i] <= 1'b0;
            end else if (wr_power) begin
               pu_q[i] <= pu_wr[i];
            end
         end
      end
   end

   // unclamped flags hold until the host powers the channel up again
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oc_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (det_s[i]) begin
               oc_q[i] <= 1'b1;
            end else if (clamp) begin
               oc_q[i] <= 1'b0;
            end else if (wr_power && pu_wr[i]) begin
               oc_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         therm_q <= 1'b0;
      end else if (hot) begin
         therm_q <= 1'b1;
      end else if (wr_power) begin
         therm_q <= 1'b0;
      end
   end

   // =====
   // readback; read frames change no state
   logic [15:0] rd_data;

   always_comb begin
      rd_data = 16'h0000;
      unique case (sel)
         dacdec_pkg::SEL_DAC: begin
            if (hit == 2'h2) begin
               rd_data = pend_q[1];
            end else if (hit != 2'h0) begin
               rd_data = pend_q[0];
            end
         end
         dacdec_pkg::SEL_RANGE: begin
            if (hit == 2'h2) begin
               rd_data = {13'h0000, range_q[1]};
            end else if (hit != 2'h0) begin
               rd_data = {13'h0000, range_q[0]};
            end
         end
         dacdec_pkg::SEL_POWER: begin
            // bit 10 and the gaps read as zero
            rd_data[dacdec_pkg::PWR_PU_A] = pu_q[0];
            rd_data[dacdec_pkg::PWR_PU_B] = pu_q[1];
            rd_data[dacdec_pkg::PWR_THERM] = therm_q;
            rd_data[dacdec_pkg::PWR_OC_A] = oc_q[0];
            rd_data[dacdec_pkg::PWR_OC_B] = oc_q[1];
         end
         dacdec_pkg::SEL_CTRL: begin
            if (addr == dacdec_pkg::FN_CONFIG) begin
               rd_data = {12'h000, cfg_q};
            end
         end
         default: begin
            rd_data = 16'h0000;
         end
      endcase
   end

   // taken once per read frame, shifted out during the next frame
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         readback_q <= 24'h000000;
      end else if (rd_ok) begin
         readback_q <= {lnk.frame_word[23:16], rd_data};
      end
   end

   // =====
   // outputs
   // enable is registered, so the pin follows the bit one clk late
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_data_out_oe <= 1'b1;
      end else begin
         serial_data_out_oe <= ~cfg_q[dacdec_pkg::CFG_SER_OUT_DIS];
      end
   end

   assign chan_a_code             = out_q[0];
   assign chan_b_code             = out_q[1];
   assign chan_a_range            = range_q[0];
   assign chan_b_range            = range_q[1];
   assign chan_a_power_on         = pu_q[0];
   assign chan_b_power_on         = pu_q[1];
   assign clamp_enable            = cfg_q[dacdec_pkg::CFG_CLAMP];
   assign thermal_shutdown_enable = cfg_q[dacdec_pkg::CFG_THERM_EN];
   assign outputs_updated         = upd_q;
endmodule : dacdec_core

`default_nettype wire

// ### core/dacdec_link.sv
/*
 Serial link end: shifts frames in on the link clock, hands each
 complete frame over by toggle, shifts readback data out.
 Assumes the link clock runs only while the frame select is low.
*/
`default_nettype none

module dacdec_link (
   input  wire logic  sclk,
   input  wire logic  sync_n,
   input  wire logic  serial_data_in_pin,
   output logic       serial_data_out_pin,
   dacdec_link_if.link lnk
);
   logic [4:0]  cnt_q;
   logic [22:0] shin_q;
   logic [22:0] shout_q;
   logic        clr;

   // frame select high aborts a partial frame
   assign clr = sync_n | lnk.link_rst;

   // =====
   // shifting
   always_ff @(posedge sclk or posedge clr) begin
      if (clr) begin
         cnt_q               <= 5'h00;
         shin_q              <= '0;
         shout_q             <= '0;
         serial_data_out_pin <= 1'b0;
      end else begin
         if (cnt_q != 5'(dacdec_pkg::FRAME_BITS)) begin
            cnt_q <= cnt_q + 5'h01;
         end
         shin_q <= {shin_q[21:0], serial_data_in_pin};
         // readback word is held still between frames, so sampled here
         if (cnt_q == 5'h00) begin
            serial_data_out_pin <= lnk.readback_word[23];
            shout_q             <= lnk.readback_word[22:0];
         end else begin
            serial_data_out_pin <= shout_q[22];
            shout_q             <= {shout_q[21:0], 1'b0};
         end
      end
   end

   // =====
   // hand-over; extra bits beyond the frame are dropped
   always_ff @(posedge sclk or posedge lnk.link_rst) begin
      if (lnk.link_rst) begin
         lnk.frame_word   <= '0;
         lnk.frame_toggle <= 1'b0;
      end else if (cnt_q == 5'(dacdec_pkg::FRAME_BITS - 1)) begin
         lnk.frame_word   <= {shin_q, serial_data_in_pin};
         lnk.frame_toggle <= ~lnk.frame_toggle;
      end
   end
endmodule : dacdec_link

`default_nettype wire

// ### core/dacdec_sync.sv
/*
 Two-stage level synchroniser into the clk domain.
 Assumes inputs change slower than two clk periods.
*/
`default_nettype none

module dacdec_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // meta_q feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : dacdec_sync

`default_nettype wire

// ### dv/dacdec_core_tb_top.sv
/*
 Self-checking bench of the dual dac register decoder core.
 Assumes the host model and the bound port checker are compiled first.
*/
`default_nettype none

// ==========================================================
// bench
module dacdec_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          RB   = 12;
   localparam logic [15:0] MASK = 16'hfff0;
   logic        clk, sys_rst, sclk, sync_n, ser_din, ser_dout, ser_oe, ser_line;
   logic        chan_a_overcurrent_flag, chan_b_overcurrent_flag, ot, pa, pb, clamp, therm_en, upd;
   logic [15:0] code_a, code_b, rdv;
   logic [2:0]  rng_a, rng_b;
   logic [23:0] rbw;
   int          err_count = 0, checks_done = 0, upd_cnt = 0, cyc = 0, u;

   // a disabled output shows the inverse, so a stale bit never passes as data
   assign ser_line = ser_oe ? ser_dout : ~ser_dout;
   dacdec_host_model host (.sclk(sclk), .sync_n(sync_n),
      .ser_din(ser_din), .ser_dout(ser_line));
   dacdec_core #(.RES_BITS(RB)) uut (
      .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .sync_n(sync_n),
      .serial_data_in_pin(ser_din), .serial_data_out_pin(ser_dout),
      .serial_data_out_oe(ser_oe), .chan_a_oc_detect(chan_a_overcurrent_flag), .chan_b_oc_detect(chan_b_overcurrent_flag),
      .overtemp_detect(ot), .chan_a_code(code_a), .chan_b_code(code_b),
      .chan_a_range(rng_a), .chan_b_range(rng_b), .chan_a_power_on(pa),
      .chan_b_power_on(pb), .clamp_enable(clamp), .thermal_shutdown_enable(therm_en),
      .outputs_updated(upd));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // decode latency is 3 to 4 clk, so 8 clk settles every frame
   task automatic wr(input logic [2:0] sel, input logic [2:0] ad, input logic [15:0] d);
      host.xfer({2'b00, sel, ad, d}, rbw);
      repeat (8) @(negedge clk);
   endtask : wr

   task automatic rd(input logic [2:0] sel, input logic [2:0] ad);
      host.xfer({2'b10, sel, ad, 16'h0000}, rbw);
      repeat (8) @(negedge clk);
      wr(3'h3, dacdec_pkg::FN_NOP, 16'h0000);
      rdv = rbw[15:0];
   endtask : rd

   task automatic t_code();
      wr(3'h0, dacdec_pkg::ADDR_A, 16'h1234);
      wr(3'h0, dacdec_pkg::ADDR_B, 16'habcd);
      chk(code_a, 16'h0000);
      u = upd_cnt;
      wr(3'h3, dacdec_pkg::FN_LOAD, 16'hffff);
      chk(code_a, 16'h1234 & MASK);
      chk(code_b, 16'habcd & MASK);
      chk(16'(upd_cnt - u), 16'h0001);
      wr(3'h0, dacdec_pkg::ADDR_BOTH, 16'h5a5f);
      wr(3'h0, 3'h6, 16'h1111);
      host.xfer({2'b01, 3'h0, dacdec_pkg::ADDR_A, 16'h2222}, rbw);
      repeat (8) @(negedge clk);
      wr(3'h3, dacdec_pkg::FN_LOAD, 16'h0000);
      chk(code_a, 16'h5a5f & MASK);
      chk(code_b, 16'h5a5f & MASK);
   endtask : t_code

   task automatic t_range();
      for (int i = 0; i < 8; i++) begin
         wr(3'h1, dacdec_pkg::ADDR_A, {13'h1fff, i[2:0]});
         chk({13'h0, rng_a}, (i < 6) ? 16'(i) : 16'h0005);
      end
      wr(3'h1, dacdec_pkg::ADDR_B, 16'hfff9);
      wr(3'h1, 3'h1, 16'h0002);
      chk({10'h0, rng_a, rng_b}, 16'h0029);
   endtask : t_range

   task automatic t_ctrl();
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'hfffb);
      chk({13'h0, ser_oe, clamp, therm_en}, 16'h0001);
      wr(3'h3, dacdec_pkg::FN_NOP, 16'hffff);
      wr(3'h3, 3'h2, 16'h0004);
      chk({13'h0, ser_oe, clamp, therm_en}, 16'h0001);
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'h0002);
      chk({13'h0, ser_oe, clamp, therm_en}, 16'h0004);
      u = upd_cnt;
      wr(3'h3, dacdec_pkg::FN_CLEAR, 16'hffff);
      chk(code_a, 16'h0000);
      chk(code_b, 16'h8000);
      chk(16'(upd_cnt - u), 16'h0001);
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'h0000);
      wr(3'h3, dacdec_pkg::FN_CLEAR, 16'h0000);
      chk(code_a, 16'h8000);
      chk(code_b, 16'h0000);
   endtask : t_ctrl

   task automatic t_power();
      wr(3'h2, 3'h2, 16'h0005);
      chk({14'h0, pa, pb}, 16'h0000);
      wr(3'h2, 3'h0, 16'h0005);
      chk({14'h0, pa, pb}, 16'h0003);
      rd(3'h2, 3'h0);
      chk(rdv, 16'h0005);
      repeat (1000) @(negedge clk); // host lets the channels settle
      chan_a_overcurrent_flag = 1'b1;
      repeat (10) @(negedge clk);
      chk({14'h0, pa, pb}, 16'h0001);
      chan_a_overcurrent_flag = 1'b0;
      rd(3'h2, 3'h0);
      chk(rdv, 16'h0084);
      wr(3'h2, 3'h0, 16'h0005);
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'h0004);
      chan_b_overcurrent_flag = 1'b1;
      repeat (10) @(negedge clk);
      rd(3'h2, 3'h0);
      chk(rdv, 16'h0205);
      chan_b_overcurrent_flag = 1'b0;
      repeat (10) @(negedge clk);
      rd(3'h2, 3'h0);
      chk(rdv, 16'h0005);
      ot = 1'b1;
      repeat (10) @(negedge clk);
      chk({14'h0, pa, pb}, 16'h0003);
      ot = 1'b0;
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'h000c);
      ot = 1'b1;
      repeat (10) @(negedge clk);
      chk({14'h0, pa, pb}, 16'h0000);
      ot = 1'b0;
      rd(3'h2, 3'h0);
      chk(rdv & 16'h0025, 16'h0020);
      wr(3'h3, dacdec_pkg::FN_CONFIG, 16'h0000);
      wr(3'h2, dacdec_pkg::ADDR_A, 16'h0004);
      chk({14'h0, pa, pb}, 16'h0001);
      chan_b_overcurrent_flag = 1'b1;
      repeat (10) @(negedge clk);
      chk({14'h0, pa, pb}, 16'h0000);
      chan_b_overcurrent_flag = 1'b0;
      rd(3'h2, 3'h0);
      chk(rdv, 16'h0200);
   endtask : t_power

   initial begin
      sys_rst = 1'b1;
      chan_a_overcurrent_flag = 1'b0;
      chan_b_overcurrent_flag = 1'b0;
      ot = 1'b0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      chk({5'h0, ser_oe, clamp, therm_en, pa, pb, rng_a, rng_b}, 16'h0600);
      chk(code_a | code_b, 16'h0000);
      t_code();
      t_range();
      t_ctrl();
      t_power();
      complete_run();
   end
endmodule : dacdec_core_tb_top

`default_nettype wire

// ### dv/dacdec_host_model.sv
/*
 Host side of the serial link: sends 24-bit frames, collects readback.
 Assumes the link clock may stand still between frames.
*/
`default_nettype none

// ==========================================================
// host model
module dacdec_host_model (
   output logic      sclk,
   output logic      sync_n,
   output logic      ser_din,
   input  wire logic ser_dout
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      ser_din = 1'b0;
   end

   // 15 ns link period; clock stands still outside frames
   task automatic xfer(input logic [23:0] w, output logic [23:0] rb);
      sync_n = 1'b0;
      #7.5;
      for (int i = 23; i >= 0; i--) begin // msb first, all 24 bits of w sent as given
         ser_din = w[i];
         #7.5 sclk = 1'b1;
         #7.5 sclk = 1'b0;
         rb[i] = ser_dout;
      end
      #7.5 sync_n = 1'b1;
      ser_din = ~ser_din; // released line must not look like the last bit
      #15;
   endtask : xfer
endmodule : dacdec_host_model

`default_nettype wire

// ### dv/dacdec_monitor.sv
/*
 Port checker for the dual dac register decoder core, bound to its top.
 Assumes one clk domain with synchronous active-high sys_rst.
*/
`default_nettype none

// ==========================================================
// checker
module dacdec_monitor (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        chan_a_oc_detect,
   input wire logic        chan_b_oc_detect,
   input wire logic        overtemp_detect,
   input wire logic [15:0] chan_a_code,
   input wire logic [15:0] chan_b_code,
   input wire logic [2:0]  chan_a_range,
   input wire logic [2:0]  chan_b_range,
   input wire logic        chan_a_power_on,
   input wire logic        chan_b_power_on,
   input wire logic        clamp_enable,
   input wire logic        thermal_shutdown_enable,
   input wire logic        serial_data_out_oe,
   input wire logic        outputs_updated
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_PULSE: assert property (outputs_updated |=> !outputs_updated)
      else $error("update pulse longer than one cycle");
   // code outputs and the update pulse are launched by the same clk edge
   AST_CODE_A: assert property ($changed(chan_a_code) |-> outputs_updated)
      else $error("channel a code moved without an update");
   AST_CODE_B: assert property ($changed(chan_b_code) |-> outputs_updated)
      else $error("channel b code moved without an update");
   AST_RANGE: assert property (chan_a_range <= dacdec_pkg::RANGE_LAST
                               && chan_b_range <= dacdec_pkg::RANGE_LAST)
      else $error("undefined range code stored");
   AST_RESET: assert property ($fell(sys_rst) |-> serial_data_out_oe && clamp_enable
      && !thermal_shutdown_enable && !chan_a_power_on && !chan_b_power_on)
      else $error("wrong values after reset");
   // the detectors are synchronised first, so five cycles of cause are allowed
   AST_OC_A: assert property ((!clamp_enable && chan_a_oc_detect)[*5]
                              |=> !chan_a_power_on)
      else $error("channel a kept power on overcurrent");
   AST_OC_B: assert property ((!clamp_enable && chan_b_oc_detect)[*5]
                              |-> ##1 !chan_b_power_on)
      else $error("channel b kept power on overcurrent");
   AST_TSD: assert property ((thermal_shutdown_enable && overtemp_detect)[*5]
                             |=> !(chan_a_power_on || chan_b_power_on))
      else $error("overtemperature left a channel powered");
endmodule : dacdec_monitor

bind dacdec_core dacdec_monitor u_mon (
   .clk(clk), .sys_rst(sys_rst), .chan_a_oc_detect(chan_a_oc_detect),
   .chan_b_oc_detect(chan_b_oc_detect), .overtemp_detect(overtemp_detect),
   .chan_a_code(chan_a_code), .chan_b_code(chan_b_code),
   .chan_a_range(chan_a_range), .chan_b_range(chan_b_range),
   .chan_a_power_on(chan_a_power_on), .chan_b_power_on(chan_b_power_on),
   .clamp_enable(clamp_enable), .thermal_shutdown_enable(thermal_shutdown_enable),
   .serial_data_out_oe(serial_data_out_oe), .outputs_updated(outputs_updated));

`default_nettype wire

// ### shared/dacdec_link_if.sv
/*
 Carrier between the serial link end and the register core.
 Assumes frame_word is stable whenever frame_toggle has changed.
*/
`default_nettype none

interface dacdec_link_if;
   logic [23:0] frame_word;
   logic        frame_toggle;
   logic [23:0] readback_word;
   logic        link_rst;

   modport link (output frame_word, output frame_toggle,
                 input readback_word, input link_rst);
   modport core (input frame_word, input frame_toggle,
                 output readback_word, output link_rst);
endinterface : dacdec_link_if

`default_nettype wire

// ### shared/dacdec_pkg.sv
/*
 Constants for the dual DAC register decoder: frame layout, register
 select and channel codes, control functions, field positions, resets.
 Assumes frames of 24 bits arrive most significant bit first.
*/
// Functional notes
// - 24-bit frame, fields from bit 23 down
// - address 000 A, 010 B, 100 both
// - select 000 writes channel DAC code
// - code left-justified, low unused bits ignored
// - select 001 stores three-bit range code
// - range codes 000..101 valid, others undefined
// - select 011 uses address as function
// - function 000 is no-operation
// - function 001 stores four configuration bits
// - function 100 loads clear code, updates outputs
// - function 101 transfers pending codes to outputs
// - serial-out disable bit, reset zero
// - clamp enable keeps channel powered, default one
// - thermal shutdown enable bit, reset zero
// - clear level select picks clear code
// - select 010 address 000 is power register
// - power register bit layout, bit 10 zero
// - power-up bit enables channel, reset off
// - unclamped overcurrent clears power-up bit
// - overtemperature powers down both, sets flag
// - overcurrent flag set on detection
// - clamped overcurrent flag clears itself
`default_nettype none

package dacdec_pkg;
   localparam int FRAME_BITS = 24;
   localparam int RW_BIT     = 23;
   localparam int ZERO_BIT   = 22;
   localparam int SEL_LSB    = 19;
   localparam int ADDR_LSB   = 16;
   localparam int CODE_BITS  = 16;

   localparam logic [2:0] SEL_DAC   = 3'h0;
   localparam logic [2:0] SEL_RANGE = 3'h1;
   localparam logic [2:0] SEL_POWER = 3'h2;
   localparam logic [2:0] SEL_CTRL  = 3'h3;

   localparam logic [2:0] ADDR_A    = 3'h0;
   localparam logic [2:0] ADDR_B    = 3'h2;
   localparam logic [2:0] ADDR_BOTH = 3'h4;

   localparam logic [2:0] FN_NOP    = 3'h0;
   localparam logic [2:0] FN_CONFIG = 3'h1;
   localparam logic [2:0] FN_CLEAR  = 3'h4;
   localparam logic [2:0] FN_LOAD   = 3'h5;

   localparam int CFG_SER_OUT_DIS = 0;
   localparam int CFG_CLR_SEL     = 1;
   localparam int CFG_CLAMP       = 2;
   localparam int CFG_THERM_EN    = 3;
   localparam logic [3:0] CFG_RESET = 4'h4;

   localparam int PWR_PU_A  = 0;
   localparam int PWR_PU_B  = 2;
   localparam int PWR_THERM = 5;
   localparam int PWR_OC_A  = 7;
   localparam int PWR_OC_B  = 9;

   localparam logic [2:0] RANGE_RESET   = 3'h0;
   localparam logic [2:0] RANGE_BIPOLAR = 3'h3;
   localparam logic [2:0] RANGE_LAST    = 3'h5;

   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [15:0] CODE_MID   = 16'h8000;
   localparam logic [15:0] CODE_LOW   = 16'h0000;
endpackage : dacdec_pkg

`default_nettype wire
